//--- hw/pattern_fifo.sv
// Synchronous FIFO between the bit source and the symbol builder.
// Assumes one clock; valid/ready handshake on both sides.
`timescale 1ns/1ps
module pattern_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_reg];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

//--- hw/pattern_pkg.sv
// Package for the baseband data pattern source: register map, fields,
// reset values and enumerations. Used by the source and its testbench.
package pattern_pkg;

   // Register offsets (byte addresses, one word each)
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] NIBBLE_OFFSET = 8'h04;
   localparam logic [7:0] FILE_LEN_OFFSET = 8'h08;
   localparam logic [7:0] FILE_WR_OFFSET = 8'h0c;
   localparam logic [7:0] STATUS_OFFSET = 8'h10;
   localparam logic [7:0] EXT_COUNT_OFFSET = 8'h14;

   // Control fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_SOURCE_LSB = 4;
   localparam int CTRL_PN_LSB = 8;
   localparam int CTRL_RUN_LSB = 12;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [3:0] NIBBLE_RESET = 4'h0;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   typedef enum logic [2:0] {
      SRC_PN = 3'b000,
      SRC_NIBBLE = 3'b001,
      SRC_RUN = 3'b010,
      SRC_FILE = 3'b011,
      SRC_EXT = 3'b100
   } source_t;

   typedef enum logic [2:0] {
      PN_9 = 3'b000,
      PN_11 = 3'b001,
      PN_15 = 3'b010,
      PN_20 = 3'b011,
      PN_23 = 3'b100
   } pn_order_t;

   // Run length selector: N = 4 << code, code 0..4 gives 4..64
   localparam logic [2:0] RUN_MAX_CODE = 3'b100;
   localparam logic [6:0] RUN_BASE = 7'h04;

   localparam logic [22:0] PN_SEED = 23'h00_0001;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic bit_val;
      logic sync;
   } stream_word_t;

endpackage

//--- hw/pattern_source.sv
// Serial data pattern source for the real-time I/Q symbol builder.
// Assumes the external data pins are synchronous to clk and that the
// symbol builder drains the output stream with valid/ready.
// Overview of operation
// [R01] Pseudorandom source offers orders 9, 11, 15, 20 and 23.
// [R02] Fixed-nibble source repeats a settable 4-bit word without gaps.
// [R03] Run source emits N ones then N zeros, N from 4 to 64.
// [R04] All internal sources give a continuous unframed bit stream, no gaps.
// [R05] New bits enter the FIFO only while enabled; bits already in the FIFO still go out after enable clears.
// [R06] External source forwards the data pin bits in real time.
// [R07] Stored bit file plays one bit per entry in position order.
// [R08] Outside party supplies data, data clock and symbol sync.
// [R09] Each sequence comes from a maximal-length LFSR of that order.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module pattern_source
   import pattern_pkg::*;
#(
   parameter int FILE_DEPTH = 1024,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic ext_data,
   input wire logic ext_data_clk,
   input wire logic ext_symbol_sync,
   output logic bit_out,
   output logic sync_out,
   output logic bit_valid,
   input wire logic bit_ready
);
   localparam int FAW = $clog2(FILE_DEPTH);

   logic [31:0] ctrl_reg;
   logic [3:0] fixed_nibble_pattern_reg;
   logic [FAW:0] file_len_reg;
   logic [FAW-1:0] file_wr_ptr_reg;
   logic file_mem [FILE_DEPTH];
   logic [FAW-1:0] file_rd_ptr_reg;
   logic [22:0] lfsr_reg;
   logic [1:0] nib_idx_reg;
   logic [6:0] run_cnt_reg;
   logic run_level_reg;
   logic ext_clk_prev_reg;
   logic [31:0] ext_count_reg;
   logic overrun_reg;
   logic [31:0] rdata_reg;

   reg_req_t req;
   stream_word_t gen_word;
   stream_word_t fifo_out;
   logic enable;
   source_t source;
   pn_order_t pn_order;
   logic [2:0] run_code;
   logic [6:0] run_len;
   logic gen_valid;
   logic gen_ready;
   logic step;
   logic ext_edge;
   logic pn_bit;
   logic [22:0] pn_state;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign enable = ctrl_reg[CTRL_ENABLE_BIT];
   assign source = source_t'(ctrl_reg[CTRL_SOURCE_LSB +: 3]);
   assign pn_order = pn_order_t'(ctrl_reg[CTRL_PN_LSB +: 3]);
   assign run_code = (ctrl_reg[CTRL_RUN_LSB +: 3] > RUN_MAX_CODE) ?
                     RUN_MAX_CODE : ctrl_reg[CTRL_RUN_LSB +: 3];
   assign run_len = RUN_BASE << run_code;

   // Feedback taps: x^9+x^5+1, x^11+x^9+1, x^15+x^14+1,
   // x^20+x^3+1, x^23+x^18+1, all maximal length
   function automatic logic pn_feedback(input logic [22:0] s,
                                        input pn_order_t o);
      case (o)
         PN_9: pn_feedback = s[8] ^ s[4];
         PN_11: pn_feedback = s[10] ^ s[8];
         PN_15: pn_feedback = s[14] ^ s[13];
         PN_20: pn_feedback = s[19] ^ s[2];
         PN_23: pn_feedback = s[22] ^ s[17];
         default: pn_feedback = s[8] ^ s[4];
      endcase
   endfunction

   // The register is shared by all orders, so after an order change the
   // window of a shorter order can be all zero while upper bits are not
   function automatic logic pn_window_zero(input logic [22:0] s,
                                           input pn_order_t o);
      case (o)
         PN_9: pn_window_zero = (s[8:0] == 9'h000);
         PN_11: pn_window_zero = (s[10:0] == 11'h000);
         PN_15: pn_window_zero = (s[14:0] == 15'h0000);
         PN_20: pn_window_zero = (s[19:0] == 20'h0_0000);
         PN_23: pn_window_zero = (s == 23'h00_0000);
         default: pn_window_zero = (s[8:0] == 9'h000);
      endcase
   endfunction

   function automatic logic [FAW-1:0] wrap_inc(input logic [FAW-1:0] p,
                                               input logic [FAW:0] len);
      wrap_inc = ({1'b0, p} + 1'b1 >= len) ? '0 : p + 1'b1;
   endfunction

   assign pn_state = pn_window_zero(lfsr_reg, pn_order) ?
                     PN_SEED : lfsr_reg;
   assign pn_bit = pn_feedback(pn_state, pn_order);
   assign ext_edge = ext_data_clk && !ext_clk_prev_reg;

   // [R04] Continuous source
   // Internal sources offer a bit whenever enabled, so only back-pressure paces them
   always_comb begin
      gen_word.sync = 1'b0;
      gen_valid = enable;
      case (source)
         SRC_PN: gen_word.bit_val = pn_bit;
         SRC_NIBBLE: gen_word.bit_val = fixed_nibble_pattern_reg[3 - nib_idx_reg];
         SRC_RUN: gen_word.bit_val = run_level_reg;
         SRC_FILE: gen_word.bit_val = file_mem[file_rd_ptr_reg];
         SRC_EXT: begin
            gen_word.bit_val = ext_data;
            gen_word.sync = ext_symbol_sync;
            gen_valid = enable && ext_edge;
         end
         default: gen_word.bit_val = 1'b0;
      endcase
   end

   // [R05] Gated by enable
   assign step = gen_valid && gen_ready;

   // Register writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
         fixed_nibble_pattern_reg <= NIBBLE_RESET;
         file_len_reg <= '0;
         file_wr_ptr_reg <= '0;
      end else if (req.wr) begin
         case (req.addr)
            CTRL_OFFSET: ctrl_reg <= req.wdata;
            NIBBLE_OFFSET: fixed_nibble_pattern_reg <= req.wdata[3:0];
            FILE_LEN_OFFSET: begin
               file_len_reg <= req.wdata[FAW:0];
               file_wr_ptr_reg <= '0;
            end
            FILE_WR_OFFSET: file_wr_ptr_reg <= file_wr_ptr_reg + 1'b1;
            default: ;
         endcase
      end
   end

   // [R07] File storage
   // One bit per entry; writes load positions in ascending order
   always_ff @(posedge clk) begin
      if (req.wr && req.addr == FILE_WR_OFFSET) begin
         file_mem[file_wr_ptr_reg] <= req.wdata[0];
      end
   end

   // [R07] File playback
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         file_rd_ptr_reg <= '0;
      end else if (source != SRC_FILE) begin
         file_rd_ptr_reg <= '0;
      end else if (step) begin
         file_rd_ptr_reg <= wrap_inc(file_rd_ptr_reg, file_len_reg);
      end
   end

   // [R01] [R09] LFSR step
   // A zero window would lock up; the seed stands in for it, so the
   // bit sent and the bit shifted in always agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lfsr_reg <= PN_SEED;
      end else if (source == SRC_PN && step) begin
         lfsr_reg <= {pn_state[21:0], pn_bit};
      end else begin
         lfsr_reg <= pn_state;
      end
   end

   // [R02] Nibble repeat
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nib_idx_reg <= '0;
      end else if (source != SRC_NIBBLE) begin
         nib_idx_reg <= '0;
      end else if (step) begin
         nib_idx_reg <= nib_idx_reg + 1'b1;
      end
   end

   // [R03] Run pattern
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_cnt_reg <= '0;
         run_level_reg <= 1'b1;
      end else if (source != SRC_RUN) begin
         run_cnt_reg <= '0;
         run_level_reg <= 1'b1;
      end else if (step) begin
         if (run_cnt_reg == run_len - 1'b1) begin
            run_cnt_reg <= '0;
            run_level_reg <= !run_level_reg;
         end else begin
            run_cnt_reg <= run_cnt_reg + 1'b1;
         end
      end
   end

   // [R06] [R08] External capture
   // A bit the FIFO cannot take is dropped and flagged as overrun
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_clk_prev_reg <= 1'b0;
         ext_count_reg <= '0;
         overrun_reg <= 1'b0;
      end else begin
         ext_clk_prev_reg <= ext_data_clk;
         if (step && source == SRC_EXT) begin
            ext_count_reg <= ext_count_reg + 1'b1;
         end
         if (gen_valid && !gen_ready && source == SRC_EXT) begin
            overrun_reg <= 1'b1;
         end else if (req.rd && req.addr == STATUS_OFFSET) begin
            overrun_reg <= 1'b0;
         end
      end
   end

   // Register reads, data in the following cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= '0;
      end else if (req.rd) begin
         case (req.addr)
            CTRL_OFFSET: rdata_reg <= ctrl_reg;
            NIBBLE_OFFSET: rdata_reg <= {28'h000_0000, fixed_nibble_pattern_reg};
            FILE_LEN_OFFSET: rdata_reg <= 32'(file_len_reg);
            FILE_WR_OFFSET: rdata_reg <= 32'(file_wr_ptr_reg);
            STATUS_OFFSET: rdata_reg <= {23'h00_0000, overrun_reg, 5'h00,
                                         gen_ready, bit_valid, enable};
            EXT_COUNT_OFFSET: rdata_reg <= ext_count_reg;
            default: rdata_reg <= UNMAPPED_READ;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end
   assign rdata = rdata_reg;

   pattern_fifo #(
      .WIDTH($bits(stream_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) fifo_i (
      .clk(clk),
      .rst(rst),
      .in_data(gen_word),
      .in_valid(gen_valid),
      .in_ready(gen_ready),
      .out_data(fifo_out),
      .out_valid(bit_valid),
      .out_ready(bit_ready)
   );

   assign bit_out = fifo_out.bit_val;
   assign sync_out = fifo_out.sync;

   // [R03] Run length
   run_switch_a: assert property (@(posedge clk) disable iff (rst)
      (source == SRC_RUN && step && run_cnt_reg == run_len - 1'b1)
      |=> run_level_reg != $past(run_level_reg))
      else $error("run level did not flip at end of run");
   // [R03] Run count bound
   run_bound_a: assert property (@(posedge clk) disable iff (rst)
      run_cnt_reg < run_len || $changed(ctrl_reg))
      else $error("run counter beyond run length");
   // [R02] Nibble order
   nibble_step_a: assert property (@(posedge clk) disable iff (rst)
      (source == SRC_NIBBLE && step && $stable(ctrl_reg))
      |=> nib_idx_reg == $past(nib_idx_reg) + 2'd1)
      else $error("nibble index did not advance");
   // [R01] [R09] Lfsr shift
   lfsr_shift_a: assert property (@(posedge clk) disable iff (rst)
      (source == SRC_PN && step)
      |=> lfsr_reg[22:1] == $past(pn_state[21:0]) &&
          lfsr_reg[0] == $past(pn_bit))
      else $error("lfsr did not shift");
   // [R04] Gapless source
   gapless_a: assert property (@(posedge clk) disable iff (rst)
      (enable && $past(enable) && source != SRC_EXT && $stable(source))
      |-> bit_valid)
      else $error("internal source left a gap");
   // [R05] Disabled quiet
   disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
      !enable |-> !step)
      else $error("bit generated while disabled");
   // [R06] External forward
   ext_forward_a: assert property (@(posedge clk) disable iff (rst)
      (enable && source == SRC_EXT && ext_edge && gen_ready)
      |-> step && gen_word.bit_val == ext_data)
      else $error("external bit not forwarded");
   // [R07] File order
   file_order_a: assert property (@(posedge clk) disable iff (rst)
      (source == SRC_FILE && step && $stable(source))
      |=> file_rd_ptr_reg == wrap_inc($past(file_rd_ptr_reg),
                                      $past(file_len_reg)))
      else $error("file position out of order");
endmodule

//--- test/symbol_sink.sv
// Model of the I/Q symbol builder that drains the serial bit stream.
// Assumes the source offers bits with valid/ready on the one clock.
`timescale 1ns/1ps
module symbol_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic bit_out,
   input wire logic sync_out,
   input wire logic bit_valid,
   output logic bit_ready,
   input wire logic slow,
   input wire logic hold
);
   logic phase_reg;
   logic got_bits[$];
   logic got_sync[$];
   // symbols built only from taken bits
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_reg <= 1'b0;
         bit_ready <= 1'b0;
      end else begin
         phase_reg <= ~phase_reg;
         // Slow mode takes every other cycle so the FIFO sees backpressure
         bit_ready <= ~hold & (~slow | phase_reg);
         if (bit_valid && bit_ready) begin
            got_bits.push_back(bit_out);
            got_sync.push_back(sync_out);
         end
      end
   end
endmodule

//--- test/tb_top.sv
// Self-checking bench for the pattern source.
// Assumes the symbol_sink model drains the stream on the same clock.
`timescale 1ns/1ps
module tb_top
   import pattern_pkg::*;
;
   typedef struct {
      logic [31:0] ctrl;
      logic [3:0] nib;
      int a;
      int b;
      logic slow;
   } row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic ext_data = 1'b0;
   logic ext_data_clk = 1'b0;
   logic ext_symbol_sync = 1'b0;
   logic bit_out;
   logic sync_out;
   logic bit_valid;
   logic bit_ready;
   logic slow = 1'b0;
   logic hold = 1'b0;
   logic [7:0] pat = 8'hb4;
   logic [31:0] rv;
   logic e;
   logic pn;
   int bad_count = 0;
   int n_compared = 0;
   int cyc;
   int st;
   row_t rows[13];
   always #2.5 clk = ~clk;
   pattern_source pattern_source_inst (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_data(ext_data),
      .ext_data_clk(ext_data_clk), .ext_symbol_sync(ext_symbol_sync),
      .bit_out(bit_out), .sync_out(sync_out), .bit_valid(bit_valid),
      .bit_ready(bit_ready));
   symbol_sink symbol_sink_inst (.clk(clk), .rst(rst), .bit_out(bit_out),
      .sync_out(sync_out), .bit_valid(bit_valid), .bit_ready(bit_ready),
      .slow(slow), .hold(hold));
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
   task automatic collect(input int n, output int c);
      c = 0;
      while (symbol_sink_inst.got_bits.size() < n && c < 2000) begin
         @(posedge clk);
         c++;
      end
      if (symbol_sink_inst.got_bits.size() < n) begin
         bad_count++;
         $display("[ERR] %0t stream stalled", $time);
      end
   endtask
   task automatic drain();
      reg_wr(CTRL_OFFSET, 32'h0000_0000);
      slow <= 1'b0;
      hold <= 1'b0;
      repeat (40) @(posedge clk);
      check(bit_valid, 1'b0, "valid while disabled");
      symbol_sink_inst.got_bits.delete();
      symbol_sink_inst.got_sync.delete();
   endtask
   // data and sync stand around one data clock rise
   task automatic ext_bit(input logic d, input logic s);
      @(posedge clk);
      ext_data <= d;
      ext_symbol_sync <= s;
      ext_data_clk <= 1'b1;
      @(posedge clk);
      ext_data_clk <= 1'b0;
      @(posedge clk);
      ext_data <= ~d;
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end
   initial begin
      rows = '{'{32'h0000_0001, 4'h0, 9, 5, 1'b0},
         '{32'h0000_0101, 4'h0, 11, 9, 1'b0},
         '{32'h0000_0201, 4'h0, 15, 14, 1'b1},
         '{32'h0000_0301, 4'h0, 20, 3, 1'b0},
         '{32'h0000_0401, 4'h0, 23, 18, 1'b0},
         '{32'h0000_0011, 4'ha, 0, 0, 1'b0},
         '{32'h0000_0011, 4'h1, 0, 0, 1'b1},
         '{32'h0000_0021, 4'h0, 4, 0, 1'b0},
         '{32'h0000_1021, 4'h0, 8, 0, 1'b0},
         '{32'h0000_2021, 4'h0, 16, 0, 1'b1},
         '{32'h0000_3021, 4'h0, 32, 0, 1'b0},
         '{32'h0000_4021, 4'h0, 64, 0, 1'b0},
         '{32'h0000_7021, 4'h0, 64, 0, 1'b0}};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int r = 0; r < 13; r++) begin
         drain();
         slow <= rows[r].slow;
         reg_wr(NIBBLE_OFFSET, {28'h000_0000, rows[r].nib});
         reg_wr(CTRL_OFFSET, rows[r].ctrl);
         collect(160, cyc);
         if (!rows[r].slow) check(cyc > 164, 1'b0, "stream gap");
         pn = rows[r].ctrl[6:4] == SRC_PN;
         st = pn ? rows[r].a : 0;
         for (int i = st; i < 160; i++) begin
            if (pn)
               e = symbol_sink_inst.got_bits[i - rows[r].a] ^
                  symbol_sink_inst.got_bits[i - rows[r].b];
            else if (rows[r].ctrl[6:4] == SRC_NIBBLE)
               e = rows[r].nib[3 - i % 4];
            else
               e = (i % (2 * rows[r].a)) < rows[r].a;
            check(symbol_sink_inst.got_bits[i], e, "bit");
         end
         $display("test row %0d done", r);
      end
      drain();
      hold <= 1'b1;
      reg_wr(CTRL_OFFSET, 32'h0000_0021);
      repeat (40) @(posedge clk);
      reg_rd(STATUS_OFFSET, rv);
      check(rv[2:0], 3'b011, "full status");
      hold <= 1'b0;
      collect(40, cyc);
      for (int i = 0; i < 40; i++)
         check(symbol_sink_inst.got_bits[i], (i % 8) < 4, "stall");
      $display("test fifo stall done");
      drain();
      reg_wr(FILE_LEN_OFFSET, 32'h0000_0008);
      for (int i = 0; i < 8; i++)
         reg_wr(FILE_WR_OFFSET, {31'h0000_0000, pat[i]});
      reg_rd(FILE_WR_OFFSET, rv);
      check(rv, 32'h0000_0008, "file pointer");
      reg_wr(CTRL_OFFSET, 32'h0000_0031);
      collect(24, cyc);
      for (int i = 0; i < 24; i++)
         check(symbol_sink_inst.got_bits[i], pat[i % 8], "file bit");
      $display("test file done");
      drain();
      reg_wr(CTRL_OFFSET, 32'h0000_0041);
      for (int i = 0; i < 8; i++) ext_bit(pat[i], i == 0);
      collect(8, cyc);
      for (int i = 0; i < 8; i++) begin
         check(symbol_sink_inst.got_bits[i], pat[i], "ext bit");
         check(symbol_sink_inst.got_sync[i], i == 0, "ext sync");
      end
      reg_rd(EXT_COUNT_OFFSET, rv);
      check(rv, 32'h0000_0008, "ext count");
      hold <= 1'b1;
      for (int i = 0; i < 20; i++) ext_bit(i[0], 1'b0);
      reg_rd(STATUS_OFFSET, rv);
      check(rv[8], 1'b1, "overrun set");
      reg_rd(STATUS_OFFSET, rv);
      check(rv[8], 1'b0, "overrun clear");
      $display("test ext done");
      drain();
      reg_wr(CTRL_OFFSET, 32'h0000_0011);
      repeat (10) @(posedge clk);
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      check(bit_valid, 1'b0, "valid in reset");
      rst <= 1'b0;
      reg_rd(CTRL_OFFSET, rv);
      check(rv, CTRL_RESET, "ctrl reset");
      reg_rd(NIBBLE_OFFSET, rv);
      check(rv, {28'h000_0000, NIBBLE_RESET}, "nibble reset");
      reg_rd(STATUS_OFFSET, rv);
      check(rv[1:0], 2'b00, "status reset");
      reg_rd(8'h20, rv);
      check(rv, UNMAPPED_READ, "unmapped read");
      #1 check(rdata, 32'h0000_0000, "rdata one cycle");
      $display("test reset done");
      close_out();
   end
endmodule
